// [rtl/sysmgt_request_packet_codec.sv]
`timescale 1ns/10ps
// Overview of operation
// R1 - upstream requests go out as posted sized writes, command 101001
// R2 - upstream count is zero; one mask doubleword follows
// R3 - all byte-mask bits in that doubleword are zero
// R4 - chain and data-error flags are zero upstream
// R5 - upstream header fields sit at their fixed bit-time positions
// R6 - type and address fields at bit-times 4-7; broadcast bit-times 2-3 reserved
// R7 - downstream requests are broadcasts, command 111010, recognised by address window
// R8 - all twelve type bits are decoded in both directions
// R9 - types 0x04x shutdown and 0x05x halt, low nibble implementation-defined
// R10 - type 0x0bx is a virtual wire: bits 3:2 wire, bit 1 assert
// R11 - 0x0e0 is interrupt pending; 0x0e2 to 0x0ff vendor wire messages
// R12 - power-management types 0x10x-0x17x only sent when software enables them
// R13 - reserved types 0x300 upward only sent when enabled; 0x00x reserved
// R14 - legacy processor encodings recognised and passed on as one class
// R15 - halt and shutdown originate at the host and broadcast downstream
// R16 - host sends halt on halt instruction, shutdown on catastrophic error
// R17 - packets forward upstream and downstream regardless of local features
// R18 - one class output per type, most specific range winning
module sysmgt_request_packet_codec #(
  parameter logic [sysmgt_pkg::ADDR_W-1:20] ADDR_BASE = sysmgt_pkg::SYSMGT_ADDR_BASE,
  parameter logic                           IS_HOST   = 1'b0
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // local request to transmit
  input  wire logic                     txValid,
  output logic                          txReady,
  input  wire sysmgt_pkg::request_t     txRequest,
  input  wire logic                     txDownstream,
  input  wire logic                     haltEvent,
  input  wire logic                     shutdownEvent,
  input  wire logic [3:0]               specialDetail,
  input  wire logic                     powerMgmtEnable,
  input  wire logic                     reservedTypeEnable,
  output logic                          txRefused,
  // link transmit side, 8 bit-times per header
  output logic                          linkTxValid,
  input  wire logic                     linkTxReady,
  output logic [7:0]                    linkTxByte,
  output logic                          linkTxLast,
  // link receive side
  input  wire logic                     linkRxValid,
  input  wire logic [7:0]               linkRxByte,
  // decoded receive results
  output logic                          rxValid,
  output sysmgt_pkg::request_t          rxRequest,
  output logic                          rxUpstream,
  output sysmgt_pkg::req_class_t        rxClass,
  output sysmgt_pkg::wire_event_t       rxWire,
  output logic                          rxForward
);

  ////////////////////////////////////////////////////////////////////////////
  // request classification

  function automatic sysmgt_pkg::req_class_t classify(input logic [11:0] t);
    sysmgt_pkg::req_class_t c;
    c = sysmgt_pkg::REQ_RESERVED;
    // most specific ranges tested first, so nested ranges resolve correctly
    if (t[11:4] == 8'h00) begin
      c = sysmgt_pkg::REQ_RESERVED;  // R13 R18
    end else if (t[11:4] == 8'h04) begin
      c = sysmgt_pkg::REQ_SHUTDOWN;  // R9
    end else if (t[11:4] == 8'h05) begin
      c = sysmgt_pkg::REQ_HALT;  // R9
    end else if (t[11:4] == 8'h0b) begin
      c = sysmgt_pkg::REQ_VIRTUAL_WIRE;  // R10
    end else if (t == 12'h0e0) begin
      c = sysmgt_pkg::REQ_INT_PENDING;  // R11
    end else if (t == 12'h0e1) begin
      c = sysmgt_pkg::REQ_LEGACY;  // R14
    end else if (t[11:4] >= 8'h0e && t[11:4] <= 8'h0f) begin
      c = sysmgt_pkg::REQ_VENDOR_WIRE;  // R11
    end else if (t[11:6] == 6'h00 || t[11:5] == 7'h03 || t[11:5] == 7'h04 ||
                 t[11:4] == 8'h0a || t[11:5] == 7'h06 || t[11:7] == 5'h03 ||
                 t[11:8] == 4'h2) begin
      c = sysmgt_pkg::REQ_LEGACY;  // R14
    end else if (t[11:7] == 5'h02) begin
      c = sysmgt_pkg::REQ_POWER_MGMT;  // R12
    end
    return c;  // R8
  endfunction : classify

  ////////////////////////////////////////////////////////////////////////////
  // transmit: select source, gate by enables, build header

  sysmgt_pkg::request_t txSel;
  logic                 selDown;
  logic                 selValid;
  logic                 gateOk;
  sysmgt_pkg::req_class_t selClass;

  always_comb begin
    txSel            = txRequest;
    selDown          = txDownstream;
    selValid         = txValid;
    // special cycles are built only by a host and always go down
    if (IS_HOST && (haltEvent || shutdownEvent)) begin  // R15 R16
      txSel.request_type_field = {4'h0, (haltEvent ? 4'h5 : 4'h4), specialDetail};
      selDown  = 1'b1;
      selValid = 1'b1;
    end
  end

  assign selClass = classify(txSel.request_type_field);
  assign gateOk   = !(selClass == sysmgt_pkg::REQ_POWER_MGMT && !powerMgmtEnable) &&  // R12
                    !(txSel.request_type_field >= 12'h300 && !reservedTypeEnable);    // R13

  logic [63:0] header;
  logic [63:0] next_header;

  always_comb begin
    next_header = 64'h0;
    next_header[sysmgt_pkg::POS_CMD +: 6] =
      selDown ? sysmgt_pkg::CMD_BROADCAST : sysmgt_pkg::CMD_SIZED_WRITE;  // R1 R7
    next_header[sysmgt_pkg::POS_SEQ_HI +: 2] = txSel.ordering_sequence_tag[3:2];  // R5
    next_header[sysmgt_pkg::POS_UNIT +: 5]   = txSel.source_unit_tag;
    next_header[sysmgt_pkg::POS_SEQ_LO +: 2] = txSel.ordering_sequence_tag[1:0];
    next_header[sysmgt_pkg::POS_PASS_PW]     = txSel.pass_posted_write_flag;
    if (!selDown) begin
      next_header[sysmgt_pkg::POS_COUNT_LO +: 2] = sysmgt_pkg::SIZED_COUNT[1:0];  // R2
      next_header[sysmgt_pkg::POS_COUNT_HI +: 2] = sysmgt_pkg::SIZED_COUNT[3:2];
      next_header[sysmgt_pkg::POS_CHAIN]         = 1'b0;  // R4
      next_header[sysmgt_pkg::POS_DATA_ERR]      = 1'b0;  // R4
    end
    next_header[sysmgt_pkg::POS_TYPE_LO +: 8]    = txSel.request_type_field[7:0];  // R6
    next_header[sysmgt_pkg::POS_TYPE_HI +: 4]    = txSel.request_type_field[11:8];
    next_header[sysmgt_pkg::POS_ADDR_23_20 +: 4] = ADDR_BASE[23:20];
    next_header[sysmgt_pkg::POS_ADDR_39_24 +: 16] = ADDR_BASE[39:24];
  end

  typedef enum {TX_IDLE, TX_HEAD, TX_MASK} tx_state_t;
  tx_state_t   txState;
  logic [3:0]  txCount;

  // refusal is a single-cycle answer; nothing is sent for a refused request
  assign txReady = (txState == TX_IDLE);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txState   <= TX_IDLE;
      txCount   <= 4'h0;
      header    <= 64'h0;
      txRefused <= 1'b0;
    end else begin
      txRefused <= 1'b0;
      unique case (txState)
        TX_IDLE: begin
          if (selValid && gateOk) begin
            header  <= next_header;
            txCount <= 4'h0;
            txState <= TX_HEAD;
          end else if (selValid) begin
            txRefused <= 1'b1;  // R12 R13
          end
        end
        TX_HEAD: begin
          if (linkTxReady) begin
            if (txCount == 4'h7) begin
              txCount <= 4'h0;
              // a broadcast has no data; the sized write carries one mask word
              txState <= (header[5:0] == sysmgt_pkg::CMD_BROADCAST) ? TX_IDLE : TX_MASK;
            end else begin
              txCount <= txCount + 4'h1;
            end
          end
        end
        TX_MASK: begin
          if (linkTxReady) begin
            if (txCount == 4'h3) begin
              txState <= TX_IDLE;
            end else begin
              txCount <= txCount + 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    linkTxValid = (txState != TX_IDLE);
    linkTxByte  = 8'h00;
    linkTxLast  = 1'b0;
    if (txState == TX_HEAD) begin
      linkTxByte = header[{txCount[2:0], 3'b000} +: 8];  // R5 R6
      linkTxLast = (txCount == 4'h7) && (header[5:0] == sysmgt_pkg::CMD_BROADCAST);
    end else if (txState == TX_MASK) begin
      linkTxByte = sysmgt_pkg::MASK_WORD[{txCount[1:0], 3'b000} +: 8];  // R3
      linkTxLast = (txCount == 4'h3);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive: collect eight bit-times, decode, drop trailing mask word

  logic [63:0] rxShift;
  logic [3:0]  rxCount;
  logic [2:0]  rxSkip;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxShift <= 64'h0;
      rxCount <= 4'h0;
      rxSkip  <= 3'h0;
    end else if (linkRxValid) begin
      if (rxSkip != 3'h0) begin
        rxSkip <= rxSkip - 3'h1;
      end else begin
        rxShift <= {linkRxByte, rxShift[63:8]};
        if (rxCount == 4'h7) begin
          rxCount <= 4'h0;
          rxSkip  <= (rxShift[13:8] == sysmgt_pkg::CMD_SIZED_WRITE) ? 3'h4 : 3'h0;
        end else begin
          rxCount <= rxCount + 4'h1;
        end
      end
    end
  end

  logic [63:0] rxHead;
  logic        rxDone;
  logic        rxMatch;
  logic [11:0] rxType;

  assign rxHead  = {linkRxByte, rxShift[63:8]};
  assign rxDone  = linkRxValid && rxSkip == 3'h0 && rxCount == 4'h7;
  assign rxType  = {rxHead[sysmgt_pkg::POS_TYPE_HI +: 4], rxHead[sysmgt_pkg::POS_TYPE_LO +: 8]};
  // identified by command code and the system management address window
  assign rxMatch = (rxHead[5:0] == sysmgt_pkg::CMD_BROADCAST ||
                    rxHead[5:0] == sysmgt_pkg::CMD_SIZED_WRITE) &&
                   rxHead[sysmgt_pkg::POS_ADDR_23_20 +: 4] == ADDR_BASE[23:20] &&
                   rxHead[sysmgt_pkg::POS_ADDR_39_24 +: 16] == ADDR_BASE[39:24];  // R7

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxValid    <= 1'b0;
      rxRequest  <= '0;
      rxUpstream <= 1'b0;
      rxClass    <= sysmgt_pkg::REQ_NONE;
      rxWire     <= '0;
      rxForward  <= 1'b0;
    end else begin
      rxValid   <= rxDone && rxMatch;
      rxForward <= rxDone && rxMatch;  // R17
      rxWire.valid <= 1'b0;
      if (rxDone && rxMatch) begin
        rxRequest.ordering_sequence_tag  <= {rxHead[sysmgt_pkg::POS_SEQ_HI +: 2],
                                             rxHead[sysmgt_pkg::POS_SEQ_LO +: 2]};
        rxRequest.pass_posted_write_flag <= rxHead[sysmgt_pkg::POS_PASS_PW];
        rxRequest.source_unit_tag        <= rxHead[sysmgt_pkg::POS_UNIT +: 5];
        rxRequest.request_type_field     <= rxType;  // R8
        rxUpstream <= (rxHead[5:0] == sysmgt_pkg::CMD_SIZED_WRITE);
        rxClass    <= classify(rxType);  // R18
        rxWire.valid       <= (classify(rxType) == sysmgt_pkg::REQ_VIRTUAL_WIRE);  // R10
        rxWire.wireSel     <= rxType[3:2];
        rxWire.assertLevel <= rxType[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_upstream_mask_zero : assert property (@(posedge clk) disable iff (!reset_n)  // R3
    (txState == TX_MASK) |-> (linkTxByte == 8'h00))
    else $error("mask byte not zero");

  a_upstream_cmd_code : assert property (@(posedge clk) disable iff (!reset_n)  // R1
    (txState == TX_HEAD && txCount == 4'h0 && $past(txState) == TX_IDLE && !header[1])
    |-> linkTxByte[5:0] == sysmgt_pkg::CMD_SIZED_WRITE)
    else $error("upstream command code wrong");

  a_upstream_flags_clear : assert property (@(posedge clk) disable iff (!reset_n)  // R2 R4
    (txState == TX_HEAD && txCount == 4'h2 && header[5:0] == sysmgt_pkg::CMD_SIZED_WRITE)
    |-> linkTxByte[7:6] == 2'b00 && linkTxByte[4:3] == 2'b00)
    else $error("count, chain or data-error set");

  a_mask_follows_head : assert property (@(posedge clk) disable iff (!reset_n)  // R2
    (txState == TX_HEAD && txCount == 4'h7 && linkTxReady &&
     header[5:0] == sysmgt_pkg::CMD_SIZED_WRITE) |=> txState == TX_MASK)
    else $error("mask word missing");

  a_pm_gated : assert property (@(posedge clk) disable iff (!reset_n)  // R12
    (txState == TX_IDLE && selValid && selClass == sysmgt_pkg::REQ_POWER_MGMT &&
     !powerMgmtEnable) |=> txRefused && txState == TX_IDLE)
    else $error("power request sent while disabled");

  a_reserved_gated : assert property (@(posedge clk) disable iff (!reset_n)  // R13
    (txState == TX_IDLE && selValid && txSel.request_type_field >= 12'h300 &&
     !reservedTypeEnable) |=> txRefused)
    else $error("reserved request sent while disabled");

  a_type_byte_pos : assert property (@(posedge clk) disable iff (!reset_n)  // R6
    (txState == TX_HEAD && txCount == 4'h4) |-> linkTxByte == header[39:32])
    else $error("type byte misplaced");

  a_halt_class : assert property (@(posedge clk) disable iff (!reset_n)  // R9
    (rxDone && rxMatch && rxType[11:4] == 8'h05) |=> rxClass == sysmgt_pkg::REQ_HALT && rxValid)
    else $error("halt not classified");

  a_reserved_nested : assert property (@(posedge clk) disable iff (!reset_n)  // R18
    (rxDone && rxMatch && rxType[11:4] == 8'h00) |=> rxClass == sysmgt_pkg::REQ_RESERVED)
    else $error("nested reserved range lost");

  a_wire_decode : assert property (@(posedge clk) disable iff (!reset_n)  // R10
    (rxDone && rxMatch && rxType[11:4] == 8'h0b) |=>
    rxWire.valid && rxWire.wireSel == $past(rxType[3:2]) && rxWire.assertLevel == $past(rxType[1]))
    else $error("virtual wire misdecoded");

  a_special_broadcast : assert property (@(posedge clk) disable iff (!reset_n)  // R15
    (IS_HOST && txState == TX_IDLE && (haltEvent || shutdownEvent)) |=>
    txState == TX_HEAD && header[5:0] == sysmgt_pkg::CMD_BROADCAST)
    else $error("special cycle not broadcast");

  a_halt_type_sent : assert property (@(posedge clk) disable iff (!reset_n)  // R16
    (IS_HOST && txState == TX_IDLE && haltEvent) |=> header[43:36] == 8'h05)
    else $error("halt cycle type wrong");

  a_shutdown_type_sent : assert property (@(posedge clk) disable iff (!reset_n)  // R16
    (IS_HOST && txState == TX_IDLE && shutdownEvent && !haltEvent) |=> header[43:36] == 8'h04)
    else $error("shutdown cycle type wrong");

  a_forward_matched : assert property (@(posedge clk) disable iff (!reset_n)  // R17
    (rxDone && rxMatch) |=> rxForward && rxValid)
    else $error("matched packet not forwarded");

  a_vendor_class : assert property (@(posedge clk) disable iff (!reset_n)  // R11
    (rxDone && rxMatch && rxType >= 12'h0e2 && rxType <= 12'h0ff) |=>
    rxClass == sysmgt_pkg::REQ_VENDOR_WIRE)
    else $error("vendor wire message misclassified");

  a_foreign_ignored : assert property (@(posedge clk) disable iff (!reset_n)  // R7
    (rxDone && !rxMatch) |=> !rxValid && !rxForward)
    else $error("foreign packet decoded");

  c_upstream_sent  : cover property (@(posedge clk) txState == TX_MASK && linkTxLast);
  c_broadcast_sent : cover property (@(posedge clk) txState == TX_HEAD && linkTxLast);
  c_request_refused : cover property (@(posedge clk) txRefused);
  c_wire_received  : cover property (@(posedge clk) rxWire.valid);

endmodule : sysmgt_request_packet_codec

// [rtl/sysmgt_pkg.sv]
package sysmgt_pkg;

  // link command codes (low six bits of bit-time 0)
  localparam logic [5:0] CMD_SIZED_WRITE = 6'h29;  // 101001
  localparam logic [5:0] CMD_BROADCAST   = 6'h3a;  // 111010

  localparam int PACKET_BYTES = 8;
  localparam int UNIT_W       = 5;
  localparam int SEQ_W        = 4;
  localparam int TYPE_W       = 12;
  localparam int ADDR_W       = 40;

  // field positions inside the 64-bit header (bit-time n = bits 8n+7:8n)
  localparam int POS_CMD        = 0;
  localparam int POS_SEQ_HI     = 6;
  localparam int POS_UNIT       = 8;
  localparam int POS_SEQ_LO     = 13;
  localparam int POS_PASS_PW    = 15;
  localparam int POS_CHAIN      = 19;
  localparam int POS_DATA_ERR   = 20;
  localparam int POS_COUNT_LO   = 22;
  localparam int POS_COUNT_HI   = 24;
  localparam int POS_TYPE_LO    = 32;
  localparam int POS_TYPE_HI    = 40;
  localparam int POS_ADDR_23_20 = 44;
  localparam int POS_ADDR_39_24 = 48;

  // upper bits of the system management address window
  localparam logic [ADDR_W-1:20] SYSMGT_ADDR_BASE = 20'hfdf90;
  localparam logic [3:0]         SIZED_COUNT      = 4'h0;
  localparam logic [31:0]        MASK_WORD        = 32'h0000_0000;

  typedef enum logic [3:0] {
    REQ_NONE,
    REQ_RESERVED,
    REQ_LEGACY,
    REQ_SHUTDOWN,
    REQ_HALT,
    REQ_VIRTUAL_WIRE,
    REQ_INT_PENDING,
    REQ_VENDOR_WIRE,
    REQ_POWER_MGMT
  } req_class_t;

  typedef struct packed {
    logic [SEQ_W-1:0]  ordering_sequence_tag;
    logic              pass_posted_write_flag;
    logic [UNIT_W-1:0] source_unit_tag;
    logic [TYPE_W-1:0] request_type_field;
  } request_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] wireSel;
    logic       assertLevel;
  } wire_event_t;

endpackage : sysmgt_pkg

// [dv/link_peer_model.sv]
`timescale 1ns/10ps
module link_peer_model (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic       linkTxValid,
  input  wire logic [7:0] linkTxByte,
  input  wire logic       linkTxLast,
  output logic            linkTxReady,
  output logic            linkRxValid,
  output logic [7:0]      linkRxByte
);
  logic [7:0] got [12];
  int         count;
  int         lastAt;

  initial begin
    linkTxReady = 1'b1;
    linkRxValid = 1'b0;
    linkRxByte  = 8'h00;
    count       = 0;
    lastAt      = 0;
  end

  ////////////////////////////////////////////////////////////
  // a slow peer takes a byte only every other cycle
  always @(negedge clk) linkTxReady <= slow ? ~linkTxReady : 1'b1;

  always @(posedge clk) begin
    if (linkTxValid && linkTxReady) begin
      if (count < 12) got[count] <= linkTxByte;
      count <= count + 1;
      if (linkTxLast) lastAt <= count + 1;
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic sendByte(input logic [7:0] b);
    @(negedge clk);
    linkRxValid = 1'b1;
    linkRxByte  = b;
  endtask : sendByte

  // released lines show the inverse so a stale byte never reads as data
  task automatic idle();
    @(negedge clk);
    linkRxValid = 1'b0;
    linkRxByte  = ~linkRxByte;
  endtask : idle
endmodule : link_peer_model

// [dv/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  localparam logic [19:0] BASE = sysmgt_pkg::SYSMGT_ADDR_BASE;
  // request type, then class code (enum order) in the low nibble
  localparam logic [15:0] ROWS [20] = '{16'h0051, 16'h03f2, 16'h04a3, 16'h0534, 16'h06f2,
    16'h09f2, 16'h0a12, 16'h0b65, 16'h0b85, 16'h0c32, 16'h0e06, 16'h0e12, 16'h0e27, 16'h0ff7,
    16'h1008, 16'h17f8, 16'h1802, 16'h2ff2, 16'h3001, 16'hfff1};
  // request type, then power enable, reserved enable, refused
  localparam logic [15:0] GATE [10] = '{16'h1001, 16'h17f1, 16'h1800, 16'h2ff0, 16'h3001,
    16'hfff1, 16'h1004, 16'h3005, 16'h17f3, 16'h3002};
  logic                    clk;
  logic                    reset_n;
  logic                    txValid;
  logic                    txReady;
  sysmgt_pkg::request_t    txRequest;
  logic                    txDownstream;
  logic                    haltEvent;
  logic                    shutdownEvent;
  logic [3:0]              specialDetail;
  logic                    powerMgmtEnable;
  logic                    reservedTypeEnable;
  logic                    txRefused;
  logic                    linkTxValid;
  logic                    linkTxReady;
  logic [7:0]              linkTxByte;
  logic                    linkTxLast;
  logic                    linkRxValid;
  logic [7:0]              linkRxByte;
  logic                    rxValid;
  sysmgt_pkg::request_t    rxRequest;
  logic                    rxUpstream;
  sysmgt_pkg::req_class_t  rxClass;
  sysmgt_pkg::wire_event_t rxWire;
  logic                    rxForward;
  logic                    slow;
  int                      checks;
  int                      fails;
  int                      cycles;

  sysmgt_request_packet_codec #(.ADDR_BASE(BASE), .IS_HOST(1'b1)) DUT (.clk(clk),
    .reset_n(reset_n), .txValid(txValid), .txReady(txReady), .txRequest(txRequest),
    .txDownstream(txDownstream), .haltEvent(haltEvent), .shutdownEvent(shutdownEvent),
    .specialDetail(specialDetail), .powerMgmtEnable(powerMgmtEnable),
    .reservedTypeEnable(reservedTypeEnable), .txRefused(txRefused), .linkTxValid(linkTxValid),
    .linkTxReady(linkTxReady), .linkTxByte(linkTxByte), .linkTxLast(linkTxLast),
    .linkRxValid(linkRxValid), .linkRxByte(linkRxByte), .rxValid(rxValid),
    .rxRequest(rxRequest), .rxUpstream(rxUpstream), .rxClass(rxClass), .rxWire(rxWire),
    .rxForward(rxForward));

  link_peer_model peer (.clk(clk), .slow(slow), .linkTxValid(linkTxValid),
    .linkTxByte(linkTxByte), .linkTxLast(linkTxLast), .linkTxReady(linkTxReady),
    .linkRxValid(linkRxValid), .linkRxByte(linkRxByte));

  always #20 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  function automatic logic [63:0] mkHdr(input logic [5:0] cmd, input sysmgt_pkg::request_t r,
                                        input logic [19:0] a);
    mkHdr = {a[19:4], a[3:0], r.request_type_field, 16'h0000, r.pass_posted_write_flag,
             r.ordering_sequence_tag[1:0], r.source_unit_tag, r.ordering_sequence_tag[3:2], cmd};
  endfunction : mkHdr

  task automatic txCase(input logic [11:0] t, input logic down, input logic refuse,
                        input logic [1:0] ev, input logic [11:0] expType);
    logic [63:0] h;
    logic        bc;
    bc = down || (ev != 2'b00);
    h = mkHdr(bc ? 6'h3a : 6'h29, '{4'h9, 1'b0, 5'h16, expType}, BASE);
    // one edge between calls, so a strobe is never lowered and raised at once
    @(negedge clk);
    for (int k = 0; k < 50 && txReady !== 1'b1; k++) @(negedge clk);
    peer.count = 0;
    peer.lastAt = 0;
    txRequest = '{4'h9, 1'b0, 5'h16, t};
    txDownstream = down;
    {haltEvent, shutdownEvent} = ev;
    txValid = (ev == 2'b00);
    @(negedge clk);
    txValid = 1'b0;
    {haltEvent, shutdownEvent} = 2'b00;
    check(txRefused, refuse);
    check(linkTxValid, !refuse);
    for (int k = 0; k < 60 && !refuse && peer.lastAt == 0; k++) @(negedge clk);
    check(64'(peer.lastAt), 64'(refuse ? 0 : (bc ? 8 : 12)));
    for (int k = 0; k < 8 && !refuse; k++) check(peer.got[k], h[8*k+:8]);
    for (int k = 8; k < 12 && !refuse && !bc; k++) check(peer.got[k], 8'h00);
  endtask : txCase

  task automatic rxCase(input logic [11:0] t, input logic [5:0] cmd, input logic [19:0] a,
                        input logic hit, input logic [3:0] cls);
    sysmgt_pkg::request_t r;
    logic                 up;
    r = '{4'h6, 1'b1, 5'h0d, t};
    up = (cmd == 6'h29);
    for (int k = 0; k < 8; k++) peer.sendByte(8'(mkHdr(cmd, r, a) >> (8 * k)));
    for (int k = 0; k < 2; k++) begin
      if (up) peer.sendByte(8'h00);
      else peer.idle();
      check(rxValid, hit && k == 0);
      check(rxForward, hit && k == 0);
      check(rxWire.valid, hit && k == 0 && cls == 4'h5);
      if (hit && k == 0) begin
        check(rxRequest, r);
        check(rxUpstream, up);
        check(rxClass, cls);
        if (cls == 4'h5) check(rxWire[2:0], t[3:1]);
      end
    end
    if (up) repeat (2) peer.sendByte(8'h00);
    peer.idle();
  endtask : rxCase

  ////////////////////////////////////////////////////////////
  initial begin
    {clk, reset_n, txValid, txDownstream, haltEvent, shutdownEvent, slow} = 7'h00;
    {powerMgmtEnable, reservedTypeEnable, specialDetail} = 6'h00;
    txRequest = '0;
    {checks, fails, cycles} = {32'd0, 32'd0, 32'd0};
    repeat (10) @(negedge clk);
    check({txReady, linkTxValid, rxValid, txRefused, rxWire.valid}, 5'h10);
    check(rxClass, sysmgt_pkg::REQ_NONE);
    reset_n = 1'b1;
    $display("reset test done");
    {powerMgmtEnable, reservedTypeEnable} = 2'b11;
    foreach (ROWS[i]) begin
      slow = i[0];
      txCase(ROWS[i][15:4], i[0], 1'b0, 2'b00, ROWS[i][15:4]);
      rxCase(ROWS[i][15:4], i[0] ? 6'h29 : 6'h3a, BASE, 1'b1, ROWS[i][3:0]);
    end
    $display("type table test done");
    foreach (GATE[i]) begin
      {powerMgmtEnable, reservedTypeEnable} = GATE[i][2:1];
      txCase(GATE[i][15:4], i[0], GATE[i][0], 2'b00, GATE[i][15:4]);
    end
    $display("enable gating test done");
    specialDetail = 4'h9;
    txCase(12'h0b6, 1'b0, 1'b0, 2'b10, 12'h059);
    txCase(12'h0b6, 1'b0, 1'b0, 2'b01, 12'h049);
    txCase(12'h0b6, 1'b1, 1'b0, 2'b11, 12'h059);
    $display("special cycle test done");
    rxCase(12'h04a, 6'h3a, BASE ^ 20'h00001, 1'b0, 4'h0);
    rxCase(12'h04a, 6'h29, BASE ^ 20'h80000, 1'b0, 4'h0);
    rxCase(12'h04a, 6'h2c, BASE, 1'b0, 4'h0);
    $display("receive refusal test done");
    for (int k = 0; k < 50 && txReady !== 1'b1; k++) @(negedge clk);
    txValid = 1'b1;
    @(negedge clk);
    txValid = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b0;
    @(negedge clk);
    check({txReady, linkTxValid}, 2'b10);
    reset_n = 1'b1;
    txCase(12'h0e0, 1'b0, 1'b0, 2'b00, 12'h0e0);
    $display("mid-packet reset test done");
    test_done();
  end
endmodule : tb_top
